/* File: hw/amrp_pkg.sv */
// Purpose: shared constants and types for the management register port
// Assumes: one 20 MHz clock on both ends
// Notes:   byte-wide registers, six-bit register index
package amrp_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int REG_COUNT = 64;
  localparam logic [ADDR_W-1:0] INT_COND_ADDR = 6'h07;
  localparam logic [ADDR_W-1:0] INT_MASK_ADDR = 6'h0a;
  localparam int PARITY_ERR_BIT = 0;
  localparam int EVENT_W = 8;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] INT_MASK_RESET = 8'h00;
  localparam int ACCESS_CYCLES = 2;
  localparam logic [1:0] ACCESS_LAST = 2'h1;
  typedef logic [ADDR_W-1:0] amrp_addr_t;
  typedef logic [DATA_W-1:0] amrp_data_t;
endpackage

/* File: hw/amrp_if.sv */
// Purpose: wires of the management port between controller and device
// Assumes: testbench resolves open-drain and shared data from enables
// Notes:   ack and interrupt are open drain, active low on the wire
`timescale 1ns/1ps
interface amrp_if;
  import amrp_pkg::*;
  logic       enableN;
  logic       readNotWrite;
  amrp_addr_t regAddr;
  amrp_data_t ctlData;
  logic       ctlParity;
  logic       ctlDataOe;
  amrp_data_t devData;
  logic       devParity;
  logic       devDataOe;
  logic       ackOe;
  logic       intOe;
  amrp_data_t portData;
  logic       portParity;
  logic       ackN;
  logic       intN;
  assign portData   = devDataOe ? devData : (ctlDataOe ? ctlData : 8'hff);
  assign portParity = devDataOe ? devParity : (ctlDataOe ? ctlParity : 1'b1);
  assign ackN       = !ackOe;
  assign intN       = !intOe;
  modport device (input enableN, readNotWrite, regAddr, portData, portParity,
                  output devData, devParity, devDataOe, ackOe, intOe);
  modport ctrl   (input ackN, intN, portData, portParity,
                  output enableN, readNotWrite, regAddr, ctlData, ctlParity, ctlDataOe);
endinterface

/* File: hw/amrp_parity.sv */
// Purpose: odd parity bit over one data byte
// Assumes: nothing
// Notes:   shared by both ends
`timescale 1ns/1ps
module amrp_parity
  import amrp_pkg::*;
(
  input  amrp_pkg::amrp_data_t data,
  output logic                 parity
);
  assign parity = ~(^data);
endmodule // amrp_parity

/* File: hw/amrp_device.sv */
// Overview of operation
// - clockless handshake, acknowledge marks completion
// - sixty-four byte registers, six-bit address
// - cycles start only while enable low
// - controller holds lines valid while enabled
// - direction high reads, low writes
// - pull acknowledge low on completion
// - drive data and parity while acknowledging (device drives them only while acknowledging a read)
// - controller holds write data until acknowledge
// - acknowledge stays low while enable low
// - odd parity over eight data lines
// - bad-parity write ignored, flag raised
// - pull interrupt low on recorded condition
// - controller reads condition register after interrupt
// - masked conditions never raise interrupt
//
// Purpose: device end of the management register port
// Assumes: port inputs synchronous to ref_clk
// Notes:   condition register bits clear on write of one
//          interrupt follows the unmasked conditions one cycle late
//          an enable dropped mid-cycle abandons the access
`timescale 1ns/1ps
module amrp_device
  import amrp_pkg::*;
(
  input  logic                  ref_clk,
  input  logic                  sys_rst,
  amrp_if.device                port,
  input  logic [EVENT_W-1:0]    eventIn,
  output amrp_pkg::amrp_data_t  regView [REG_COUNT]
);
  import amrp_pkg::*;

  // access sequencing: wait out the busy cycles, then hold the answer
  typedef enum logic [1:0] {
    IDLE,
    BUSY,
    ACKED
  } amrp_dstate_t;

  // whole device state in one record, registered in one place
  typedef struct packed {
    amrp_dstate_t                     state;
    logic [1:0]                       cnt;
    amrp_data_t                       rdData;
    logic                             rdOe;
    logic                             ack;
    logic                             irq;
    logic [REG_COUNT-1:0][DATA_W-1:0] regs;
  } amrp_dev_t;

  // register file image loaded by reset; the mask entry has its own default
  function automatic logic [REG_COUNT-1:0][DATA_W-1:0] reset_image();
    logic [REG_COUNT-1:0][DATA_W-1:0] img;
    img                = {REG_COUNT{REG_RESET}};
    img[INT_MASK_ADDR] = INT_MASK_RESET;
    return img;
  endfunction

  localparam logic [REG_COUNT-1:0][DATA_W-1:0] REGS_RESET = reset_image();
  localparam amrp_data_t                       ERR_FLAG   = amrp_data_t'(1) << PARITY_ERR_BIT;

  amrp_dev_t            s_q;
  amrp_dev_t            s_d;

  // port lines as sampled on this edge; the controller holds them while enabled
  logic                 enabled;
  logic                 portRead;
  amrp_addr_t           portAddr;
  amrp_data_t           portWord;
  logic                 portPar;

  // decode of the cycle that completes on this edge
  logic                 cycleStart;
  logic                 cycleLast;
  logic                 cycleAbort;
  logic                 cycleRead;
  logic                 cycleWrite;
  logic                 wrParity;
  logic                 rdParity;
  logic                 parityBad;
  logic                 writeOk;
  amrp_data_t           readWord;
  amrp_data_t           parityFlag;
  amrp_data_t           pending;
  logic [REG_COUNT-1:0] hitSel;
  logic [REG_COUNT-1:0] wrSel;
  amrp_data_t           regNext [REG_COUNT];

  amrp_parity u_wpar (
    .data   (portWord),
    .parity (wrParity)
  );

  // read parity follows the registered byte, so it never lags the data lines
  amrp_parity u_rpar (
    .data   (s_q.rdData),
    .parity (rdParity)
  );

  assign enabled    = !port.enableN;
  assign portRead   = port.readNotWrite;
  assign portAddr   = port.regAddr;
  assign portWord   = port.portData;
  assign portPar    = port.portParity;

  // lines are judged only on the last busy cycle, after they have had time to settle
  assign cycleStart = (s_q.state == IDLE) && enabled;
  assign cycleLast  = (s_q.state == BUSY) && enabled && (s_q.cnt == ACCESS_LAST);
  assign cycleAbort = (s_q.state == BUSY) && !enabled;
  assign cycleRead  = cycleLast && portRead;
  assign cycleWrite = cycleLast && !portRead;
  assign parityBad  = (portPar != wrParity);
  assign writeOk    = cycleWrite && !parityBad;
  assign readWord   = s_q.regs[portAddr];

  // a bad write only raises the flag; the addressed register keeps its value
  assign parityFlag = (cycleWrite && parityBad) ? ERR_FLAG : '0;
  assign pending    = s_q.regs[INT_COND_ADDR] & ~s_q.regs[INT_MASK_ADDR];

  // one slice per register: write enable, next value and view tap
  genvar gi;
  generate
    for (gi = 0; gi < REG_COUNT; gi++) begin : g_reg
      localparam amrp_addr_t ENTRY = ADDR_W'(gi);
      assign hitSel[gi] = (portAddr == ENTRY);
      assign wrSel[gi]  = writeOk && hitSel[gi];
      if (ENTRY == INT_COND_ADDR) begin : g_cond
        // set beats clear: an event in the clearing cycle is kept
        assign regNext[gi] = (wrSel[gi] ? (s_q.regs[gi] & ~portWord) : s_q.regs[gi])
                             | eventIn
                             | parityFlag;
      end else begin : g_plain
        assign regNext[gi] = wrSel[gi] ? portWord : s_q.regs[gi];
      end
      assign regView[gi] = s_q.regs[gi];
    end
  endgenerate

  always_comb begin
    s_d = s_q;
    for (int i = 0; i < REG_COUNT; i++) begin
      s_d.regs[i] = regNext[i];
    end
    // interrupt line lags the condition register by one cycle
    s_d.irq = |pending;
    case (s_q.state)
      IDLE: begin
        if (cycleStart) begin
          s_d.state = BUSY;
          s_d.cnt   = 2'h0;
        end
      end
      BUSY: begin
        if (cycleAbort) begin
          // enable withdrawn before completion: dropped, nothing written
          s_d.state = IDLE;
        end else if (cycleLast) begin
          s_d.state = ACKED;
          s_d.ack   = 1'b1;
          if (cycleRead) begin
            s_d.rdData = readWord;
            s_d.rdOe   = 1'b1;
          end
        end else begin
          s_d.cnt = s_q.cnt + 2'h1;
        end
      end
      ACKED: begin
        // held until the controller lets go, however long that takes
        if (!enabled) begin
          s_d.state = IDLE;
          s_d.ack   = 1'b0;
          s_d.rdOe  = 1'b0;
        end
      end
      default: begin
        s_d.state = IDLE;
        s_d.ack   = 1'b0;
        s_d.rdOe  = 1'b0;
      end
    endcase
  end

  // async reset puts the port at rest: no ack, no drive, no interrupt
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q.state  <= IDLE;
      s_q.cnt    <= 2'h0;
      s_q.rdData <= '0;
      s_q.rdOe   <= 1'b0;
      s_q.ack    <= 1'b0;
      s_q.irq    <= 1'b0;
      s_q.regs   <= REGS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ack, interrupt, data and drive straight from flops so the open-drain pins never glitch; parity decoded from the data flops
  assign port.devData   = s_q.rdData;
  assign port.devParity = rdParity;
  assign port.devDataOe = s_q.rdOe;
  assign port.ackOe     = s_q.ack;
  assign port.intOe     = s_q.irq;
endmodule // amrp_device

/* File: hw/amrp_ctrl.sv */
// Purpose: controller end of the management register port
// Assumes: user request held until done pulse
// Notes:   badParity forces a wrong parity bit for error tests
`timescale 1ns/1ps
module amrp_ctrl
  import amrp_pkg::*;
(
  input  logic                 ref_clk,
  input  logic                 sys_rst,
  amrp_if.ctrl                 port,
  input  logic                 reqValid,
  input  logic                 reqRead,
  input  amrp_pkg::amrp_addr_t reqAddr,
  input  amrp_pkg::amrp_data_t reqData,
  input  logic                 badParity,
  output logic                 done,
  output amrp_pkg::amrp_data_t rdData,
  output logic                 rdParityOk,
  output logic                 irqPending
);
  import amrp_pkg::*;
  typedef enum logic [1:0] {C_IDLE, C_WAIT, C_REL} amrp_cstate_t;
  typedef struct packed {
    amrp_cstate_t state;
    logic         en;
    logic         rd;
    amrp_addr_t   addr;
    amrp_data_t   wdata;
    logic         wpar;
    amrp_data_t   rdata;
    logic         rok;
    logic         done;
  } amrp_ctl_t;
  amrp_ctl_t s_q, s_d;
  logic wPar, rPar;
  amrp_parity u_wp (.data(reqData), .parity(wPar));
  amrp_parity u_rp (.data(port.portData), .parity(rPar));

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.state)
      C_IDLE: begin
        // request is still up in the done cycle; that is the one just served
        if (reqValid && port.ackN && !s_q.done) begin
          s_d.state = C_WAIT;
          s_d.en = 1'b1;
          s_d.rd = reqRead;
          s_d.addr = reqAddr;
          s_d.wdata = reqData;
          s_d.wpar = wPar ^ badParity;
        end
      end
      C_WAIT: begin
        if (!port.ackN) begin
          if (s_q.rd) begin
            s_d.rdata = port.portData;
            s_d.rok = (rPar == port.portParity);
          end
          s_d.en = 1'b0;
          s_d.state = C_REL;
        end
      end
      C_REL: begin
        if (port.ackN) begin
          s_d.state = C_IDLE;
          s_d.done = 1'b1;
        end
      end
      default: s_d.state = C_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign port.enableN      = !s_q.en;
  assign port.readNotWrite = s_q.rd;
  assign port.regAddr      = s_q.addr;
  assign port.ctlData      = s_q.wdata;
  assign port.ctlParity    = s_q.wpar;
  assign port.ctlDataOe    = s_q.en && !s_q.rd;
  assign done              = s_q.done;
  assign rdData            = s_q.rdata;
  assign rdParityOk        = s_q.rok;
  assign irqPending        = !port.intN;
endmodule // amrp_ctrl

/* File: testbench/amrp_monitor.sv */
// Purpose: handshake checks on the management port wires
// Assumes: one clock, reset active high
// Notes:   watches what the two ends drive
`timescale 1ns/1ps
module amrp_monitor
  import amrp_pkg::*;
(
  input logic                 ref_clk,
  input logic                 sys_rst,
  input logic                 enableN,
  input logic                 readNotWrite,
  input logic                 ackOe,
  input logic                 devDataOe,
  input amrp_pkg::amrp_data_t devData,
  input logic                 devParity,
  input logic                 ctlDataOe,
  input amrp_pkg::amrp_addr_t regAddr,
  input amrp_pkg::amrp_data_t ctlData,
  input logic                 ctlParity
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  property p_ack_lat; $fell(enableN) |-> ##[2:3] ackOe; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_ack_hold; ackOe && !enableN |=> ackOe; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped");
  property p_ack_rel; ackOe && enableN |=> !ackOe; endproperty
  a_ack_rel: assert property (p_ack_rel) else $error("ack held");
  property p_idle; enableN && !ackOe |=> !ackOe; endproperty
  a_idle: assert property (p_idle) else $error("ack unasked");
  property p_rd_drv; ackOe && readNotWrite |-> devDataOe; endproperty
  a_rd_drv: assert property (p_rd_drv) else $error("read undriven");
  property p_drv_ack; devDataOe |-> ackOe; endproperty
  a_drv_ack: assert property (p_drv_ack) else $error("data left on");
  property p_par; devDataOe |-> devParity == ~^devData; endproperty
  a_par: assert property (p_par) else $error("read parity");
  property p_rd_stable; ackOe && $past(ackOe) && readNotWrite |-> $stable(devData); endproperty
  a_rd_stable: assert property (p_rd_stable) else $error("read data moved");
  property p_no_clash; !(devDataOe && ctlDataOe); endproperty
  a_no_clash: assert property (p_no_clash) else $error("data clash");
  property p_wr_hold;
    !enableN && !$past(enableN) && !$past(ackOe)
      |-> $stable({readNotWrite, regAddr, ctlData, ctlParity});
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("request moved");
endmodule // amrp_monitor

/* File: testbench/async_mgmt_register_port_tb.sv */
// Purpose: self-checking bench joining controller and device ends
// Assumes: 20 MHz ref_clk, reset held two cycles
// Notes:   early enable release is not exercised
`timescale 1ns/1ps
module async_mgmt_register_port_tb;
  import amrp_pkg::*;
  logic               ref_clk = 1'b0;
  logic               sys_rst = 1'b1;
  logic               reqValid = 1'b0;
  logic               reqRead = 1'b0;
  amrp_addr_t         reqAddr = '0;
  amrp_data_t         reqData = '0;
  logic               badParity = 1'b0;
  logic [EVENT_W-1:0] eventIn = '0;
  logic               done, rdParityOk, irqPending;
  amrp_data_t         rdData;
  amrp_data_t         regView [REG_COUNT];
  int                 n_mismatch = 0;
  int                 samples_checked = 0;
  amrp_if u_amrp_if ();
  amrp_ctrl u_amrp_ctrl (.ref_clk(ref_clk), .sys_rst(sys_rst), .port(u_amrp_if.ctrl),
    .reqValid(reqValid), .reqRead(reqRead), .reqAddr(reqAddr), .reqData(reqData),
    .badParity(badParity), .done(done), .rdData(rdData), .rdParityOk(rdParityOk),
    .irqPending(irqPending));
  amrp_device u_amrp_device (.ref_clk(ref_clk), .sys_rst(sys_rst), .port(u_amrp_if.device),
    .eventIn(eventIn), .regView(regView));
  amrp_monitor u_amrp_monitor (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .enableN(u_amrp_if.enableN), .readNotWrite(u_amrp_if.readNotWrite),
    .ackOe(u_amrp_if.ackOe), .devDataOe(u_amrp_if.devDataOe), .devData(u_amrp_if.devData),
    .devParity(u_amrp_if.devParity), .ctlDataOe(u_amrp_if.ctlDataOe),
    .regAddr(u_amrp_if.regAddr), .ctlData(u_amrp_if.ctlData), .ctlParity(u_amrp_if.ctlParity));
  always #25 ref_clk = ~ref_clk;
  task automatic chk8(input amrp_data_t got, input amrp_data_t exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  // request held until the done pulse, then dropped at the next edge
  task automatic xfer(input logic rd, input amrp_addr_t a, input amrp_data_t d, input logic bad);
    @(posedge ref_clk);
    reqValid <= 1'b1;
    reqRead <= rd;
    reqAddr <= a;
    reqData <= d;
    badParity <= bad;
    for (int i = 0; i < 40 && done !== 1'b1; i++) @(negedge ref_clk);
    chk1(done, 1'b1);
    @(posedge ref_clk);
    reqValid <= 1'b0;
  endtask
  task automatic t_rdwr();
    amrp_addr_t al [4] = '{6'h00, 6'h01, 6'h20, 6'h3f};
    foreach (al[i]) xfer(1'b0, al[i], {al[i], 2'h2}, 1'b0);
    foreach (al[i]) begin
      chk8(regView[al[i]], {al[i], 2'h2});
      xfer(1'b1, al[i], 8'h00, 1'b0);
      chk8(rdData, {al[i], 2'h2});
      chk1(rdParityOk, 1'b1);
    end
    $display("t_rdwr done");
  endtask
  task automatic t_parity();
    xfer(1'b0, 6'h05, 8'h3c, 1'b0);
    xfer(1'b0, 6'h05, 8'hc3, 1'b1);
    chk8(regView[5], 8'h3c);
    repeat (3) @(negedge ref_clk);
    chk1(irqPending, 1'b1);
    xfer(1'b1, INT_COND_ADDR, 8'h00, 1'b0);
    chk1(rdData[PARITY_ERR_BIT], 1'b1);
    xfer(1'b0, INT_COND_ADDR, 8'h01, 1'b0);
    repeat (3) @(negedge ref_clk);
    chk1(irqPending, 1'b0);
    $display("t_parity done");
  endtask
  task automatic t_event();
    xfer(1'b0, INT_MASK_ADDR, 8'h08, 1'b0);
    @(posedge ref_clk) eventIn <= 8'h08;
    @(posedge ref_clk) eventIn <= 8'h00;
    repeat (3) @(negedge ref_clk);
    chk8(regView[INT_COND_ADDR], 8'h08);
    chk1(irqPending, 1'b0);
    xfer(1'b0, INT_MASK_ADDR, 8'h00, 1'b0);
    repeat (3) @(negedge ref_clk);
    chk1(irqPending, 1'b1);
    $display("t_event done");
  endtask
  task automatic conclude();
    $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_rdwr();
    t_parity();
    t_event();
    conclude();
  end
  // whole run is about a hundred and fifty cycles
  initial begin
    #100000;
    n_mismatch++;
    conclude();
  end
endmodule // async_mgmt_register_port_tb
